// ===== logic/flag_reset_entry.sv
module flag_reset_entry
(
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire logic                   reset_n_pin,
   input  wire flag_reset_pkg::flag_req_t flag_req,
   input  wire logic                   pull_disable_wr,
   input  wire logic                   pull_disable_wdata,
   input  wire logic                   test_clk,
   input  wire logic                   test_mode_sel,
   input  wire logic                   boundary_scan_active,
   output logic                        ext_flag_out,
   output logic                        ext_flag_oe,
   output logic [15:0]                 cpu_status_reg_one,
   output logic                        internal_pullup,
   output flag_reset_pkg::core_ctl_t   core_ctl,
   output flag_reset_pkg::tap_state_t  tap_state
);

   // ------------------------------------------------------------
   // Reset pin decode
   // ------------------------------------------------------------
   // The reset pin is active low and sampled synchronously; it joins the block reset.
   logic in_reset;
   assign in_reset = rst | ~reset_n_pin;

   // ------------------------------------------------------------
   // Flag and status register one
   // ------------------------------------------------------------
   logic [15:0] status_q;
   logic [15:0] status_d;
   logic        flag_q;
   logic        flag_d;
   logic        from_status;
   assign from_status = flag_req.status_wdata[flag_reset_pkg::FLAG_STATUS_BIT];

   // Instruction strobes win over a status write in the same cycle; set beats clear
   always_comb
   begin
      status_d = status_q;
      flag_d   = flag_q;
      if (flag_req.status_wr)
      begin
         status_d = flag_req.status_wdata;
         flag_d   = from_status;
      end
      if (flag_req.clear_instr)
         flag_d = 1'h0;
      if (flag_req.set_instr)
         flag_d = 1'h1;
      status_d[flag_reset_pkg::FLAG_STATUS_BIT] = flag_d;
   end

   always_ff @(posedge ref_clk)
   begin
      if (in_reset)
      begin
         status_q <= flag_reset_pkg::STATUS_ONE_RESET;
         flag_q   <= flag_reset_pkg::FLAG_RESET_VAL;
      end
      else
      begin
         status_q <= status_d;
         flag_q   <= flag_d;
      end
   end

   // Output enable drops only while a boundary scan runs
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ext_flag_out       <= flag_reset_pkg::FLAG_RESET_VAL;
         ext_flag_oe        <= 1'h1;
         cpu_status_reg_one <= flag_reset_pkg::STATUS_ONE_RESET;
      end
      else
      begin
         ext_flag_out       <= flag_d & ~in_reset;
         ext_flag_oe        <= ~boundary_scan_active;
         cpu_status_reg_one <= in_reset ? flag_reset_pkg::STATUS_ONE_RESET : status_d;
      end
   end

   // ------------------------------------------------------------
   // Reset pin pull-up control
   // ------------------------------------------------------------
   // The disable bit survives the pin reset so software setting persists; the pin
   // reset still forces the pull-up on so a floating line cannot release the core.
   logic pull_dis_q;
   logic pull_dis_d;
   assign pull_dis_d = (pull_disable_wr && !in_reset) ? pull_disable_wdata : pull_dis_q;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         pull_dis_q <= 1'h0;
      else
         pull_dis_q <= pull_dis_d;
   end

   // Next value is used so a write shows on the pin one edge later, like the flag
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         internal_pullup <= 1'h1;
      else
         internal_pullup <= in_reset | ~pull_dis_d;
   end

   // ------------------------------------------------------------
   // Reset entry sequencing
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ENTRY_HOLD  = 2'h0,
      ENTRY_FETCH = 2'h1,
      ENTRY_RUN   = 2'h2
   } entry_state_t;

   entry_state_t entry_q;
   entry_state_t entry_d;

   always_comb
   begin
      unique case (entry_q)
         ENTRY_HOLD:  entry_d = ENTRY_FETCH;
         ENTRY_FETCH: entry_d = ENTRY_RUN;
         ENTRY_RUN:   entry_d = ENTRY_RUN;
         default:     entry_d = ENTRY_HOLD;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (in_reset)
         entry_q <= ENTRY_HOLD;
      else
         entry_q <= entry_d;
   end

   // PC holds the vector during reset, fetches it on release, then jumps to boot code
   always_ff @(posedge ref_clk)
   begin
      if (in_reset)
      begin
         core_ctl.run      <= 1'h0;
         core_ctl.pc_load  <= 1'h1;
         core_ctl.pc_value <= flag_reset_pkg::RESET_VECTOR_ADDR;
      end
      else
      begin
         core_ctl.run      <= (entry_d == ENTRY_RUN);
         core_ctl.pc_load  <= (entry_d != ENTRY_RUN);
         core_ctl.pc_value <= (entry_d == ENTRY_RUN) ? flag_reset_pkg::BOOTLOADER_ADDR
                                                     : flag_reset_pkg::RESET_VECTOR_ADDR;
      end
   end

   // ------------------------------------------------------------
   // Test access port state machine
   // ------------------------------------------------------------
   // Test clock is treated as a synchronous input; its rising edge is detected here.
   logic tck_q;
   logic tck_rise;
   assign tck_rise = test_clk & ~tck_q;

   flag_reset_pkg::tap_state_t tap_d;
   always_comb
   begin
      unique case (tap_state)
         flag_reset_pkg::TAP_RESET:     tap_d = test_mode_sel ? flag_reset_pkg::TAP_RESET
                                                              : flag_reset_pkg::TAP_IDLE;
         flag_reset_pkg::TAP_IDLE:      tap_d = test_mode_sel ? flag_reset_pkg::TAP_SEL_DR
                                                              : flag_reset_pkg::TAP_IDLE;
         flag_reset_pkg::TAP_SEL_DR:    tap_d = test_mode_sel ? flag_reset_pkg::TAP_SEL_IR
                                                              : flag_reset_pkg::TAP_CAP_DR;
         flag_reset_pkg::TAP_CAP_DR:    tap_d = test_mode_sel ? flag_reset_pkg::TAP_EXIT1_DR
                                                              : flag_reset_pkg::TAP_SHIFT_DR;
         flag_reset_pkg::TAP_SHIFT_DR:  tap_d = test_mode_sel ? flag_reset_pkg::TAP_EXIT1_DR
                                                              : flag_reset_pkg::TAP_SHIFT_DR;
         flag_reset_pkg::TAP_EXIT1_DR:  tap_d = test_mode_sel ? flag_reset_pkg::TAP_UPDATE_DR
                                                              : flag_reset_pkg::TAP_PAUSE_DR;
         flag_reset_pkg::TAP_PAUSE_DR:  tap_d = test_mode_sel ? flag_reset_pkg::TAP_EXIT2_DR
                                                              : flag_reset_pkg::TAP_PAUSE_DR;
         flag_reset_pkg::TAP_EXIT2_DR:  tap_d = test_mode_sel ? flag_reset_pkg::TAP_UPDATE_DR
                                                              : flag_reset_pkg::TAP_SHIFT_DR;
         flag_reset_pkg::TAP_UPDATE_DR: tap_d = test_mode_sel ? flag_reset_pkg::TAP_SEL_DR
                                                              : flag_reset_pkg::TAP_IDLE;
         flag_reset_pkg::TAP_SEL_IR:    tap_d = test_mode_sel ? flag_reset_pkg::TAP_RESET
                                                              : flag_reset_pkg::TAP_CAP_IR;
         flag_reset_pkg::TAP_CAP_IR:    tap_d = test_mode_sel ? flag_reset_pkg::TAP_EXIT1_IR
                                                              : flag_reset_pkg::TAP_SHIFT_IR;
         flag_reset_pkg::TAP_SHIFT_IR:  tap_d = test_mode_sel ? flag_reset_pkg::TAP_EXIT1_IR
                                                              : flag_reset_pkg::TAP_SHIFT_IR;
         flag_reset_pkg::TAP_EXIT1_IR:  tap_d = test_mode_sel ? flag_reset_pkg::TAP_UPDATE_IR
                                                              : flag_reset_pkg::TAP_PAUSE_IR;
         flag_reset_pkg::TAP_PAUSE_IR:  tap_d = test_mode_sel ? flag_reset_pkg::TAP_EXIT2_IR
                                                              : flag_reset_pkg::TAP_PAUSE_IR;
         flag_reset_pkg::TAP_EXIT2_IR:  tap_d = test_mode_sel ? flag_reset_pkg::TAP_UPDATE_IR
                                                              : flag_reset_pkg::TAP_SHIFT_IR;
         flag_reset_pkg::TAP_UPDATE_IR: tap_d = test_mode_sel ? flag_reset_pkg::TAP_SEL_DR
                                                              : flag_reset_pkg::TAP_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         tck_q     <= 1'h0;
         tap_state <= flag_reset_pkg::TAP_RESET;
      end
      else
      begin
         tck_q <= test_clk;
         if (tck_rise)
            tap_state <= tap_d;
      end
   end

endmodule : flag_reset_entry

// ===== logic/flag_reset_pkg.sv
package flag_reset_pkg;

   // ------------------------------------------------------------
   // Reset entry and flag constants
   // ------------------------------------------------------------
   localparam logic [23:0] RESET_VECTOR_ADDR = 24'hffff00;
   localparam logic [23:0] BOOTLOADER_ADDR   = 24'hff0000; // Plain default, parameter-like
   localparam int          FLAG_STATUS_BIT   = 13;
   localparam logic        FLAG_RESET_VAL    = 1'h0;
   localparam logic [15:0] STATUS_ONE_RESET  = 16'h0000;

   // ------------------------------------------------------------
   // Test access port states (IEEE 1149.1)
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      TAP_RESET      = 4'h0,
      TAP_IDLE       = 4'h1,
      TAP_SEL_DR     = 4'h2,
      TAP_CAP_DR     = 4'h3,
      TAP_SHIFT_DR   = 4'h4,
      TAP_EXIT1_DR   = 4'h5,
      TAP_PAUSE_DR   = 4'h6,
      TAP_EXIT2_DR   = 4'h7,
      TAP_UPDATE_DR  = 4'h8,
      TAP_SEL_IR     = 4'h9,
      TAP_CAP_IR     = 4'ha,
      TAP_SHIFT_IR   = 4'hb,
      TAP_EXIT1_IR   = 4'hc,
      TAP_PAUSE_IR   = 4'hd,
      TAP_EXIT2_IR   = 4'he,
      TAP_UPDATE_IR  = 4'hf
   } tap_state_t;

   // Core-side request to the flag: instruction strobes and status write
   typedef struct packed {
      logic        set_instr;
      logic        clear_instr;
      logic        status_wr;
      logic [15:0] status_wdata;
   } flag_req_t;

   // Reset-entry outputs toward the core
   typedef struct packed {
      logic        run;
      logic        pc_load;
      logic [23:0] pc_value;
   } core_ctl_t;

endpackage : flag_reset_pkg

// ===== verif/scan_host_model.sv
// Board side: reset driver and scan emulator; test clock is still between steps
module scan_host_model
(
   input  wire logic ref_clk,
   output logic      reset_n_pin,
   output logic      test_clk,
   output logic      test_mode_sel,
   output logic      boundary_scan_active
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin has a pull-up, so the idle level is high
   initial
   begin
      reset_n_pin = 1'b1;
      test_clk = 1'b0;
      test_mode_sel = 1'b0;
      boundary_scan_active = 1'b0;
   end
   // Low holds the device, high releases it
   task automatic drive_reset(input logic level);
      @(posedge ref_clk);
      reset_n_pin <= level;
   endtask : drive_reset
   task automatic scan(input logic on);
      @(posedge ref_clk);
      boundary_scan_active <= on;
   endtask : scan
   // Select is settled before the rise so a slow sampler still sees it
   task automatic tck_step(input logic tms);
      @(posedge ref_clk);
      test_mode_sel <= tms;
      repeat (2) @(posedge ref_clk);
      test_clk <= 1'b1;
      repeat (3) @(posedge ref_clk);
      test_clk <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : tck_step
endmodule : scan_host_model

// ===== verif/flag_reset_chk.sv
module flag_reset_chk
(
   input wire logic                      ref_clk,
   input wire logic                      rst,
   input wire logic                      reset_n_pin,
   input wire flag_reset_pkg::flag_req_t flag_req,
   input wire logic                      pull_disable_wr,
   input wire logic                      pull_disable_wdata,
   input wire logic                      test_clk,
   input wire logic                      test_mode_sel,
   input wire logic                      boundary_scan_active,
   input wire logic                      ext_flag_out,
   input wire logic                      ext_flag_oe,
   input wire logic                      internal_pullup,
   input wire flag_reset_pkg::core_ctl_t core_ctl,
   input wire flag_reset_pkg::tap_state_t tap_state
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Flag answers one edge after the strobe
   property p_set; flag_req.set_instr && reset_n_pin |=> ext_flag_out; endproperty
   a_set: assert property (p_set) else $error("flag not set");
   property p_clr; flag_req.clear_instr && !flag_req.set_instr && reset_n_pin
      |=> !ext_flag_out; endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_wr; flag_req.status_wr && !flag_req.set_instr && !flag_req.clear_instr
      && reset_n_pin |=> ext_flag_out
      == $past(flag_req.status_wdata[flag_reset_pkg::FLAG_STATUS_BIT]); endproperty
   a_wr: assert property (p_wr) else $error("status write missed flag");
   // Drive is dropped only for boundary scan
   property p_oe; 1'b1 |=> ext_flag_oe == !$past(boundary_scan_active); endproperty
   a_oe: assert property (p_oe) else $error("flag drive wrong");
   property p_hold; !reset_n_pin |=> !core_ctl.run && core_ctl.pc_load && !ext_flag_out
      && internal_pullup && core_ctl.pc_value == flag_reset_pkg::RESET_VECTOR_ADDR; endproperty
   a_hold: assert property (p_hold) else $error("pin reset state wrong");
   property p_boot; $rose(reset_n_pin) ##1 reset_n_pin [*3] |-> core_ctl.run
      && core_ctl.pc_value == flag_reset_pkg::BOOTLOADER_ADDR; endproperty
   a_boot: assert property (p_boot) else $error("no branch to bootloader");
   property p_pull; pull_disable_wr && reset_n_pin
      |=> internal_pullup == !$past(pull_disable_wdata); endproperty
   a_pull: assert property (p_pull) else $error("pull-up setting lost");
   property p_tap; $rose(test_clk) && test_mode_sel && tap_state == flag_reset_pkg::TAP_IDLE
      |-> ##[1:2] tap_state == flag_reset_pkg::TAP_SEL_DR; endproperty
   a_tap: assert property (p_tap) else $error("tap did not advance");
endmodule : flag_reset_chk
bind flag_reset_entry flag_reset_chk chk_u (.ref_clk(ref_clk), .rst(rst),
   .reset_n_pin(reset_n_pin), .flag_req(flag_req), .pull_disable_wr(pull_disable_wr),
   .pull_disable_wdata(pull_disable_wdata), .test_clk(test_clk),
   .test_mode_sel(test_mode_sel), .boundary_scan_active(boundary_scan_active),
   .ext_flag_out(ext_flag_out), .ext_flag_oe(ext_flag_oe),
   .internal_pullup(internal_pullup), .core_ctl(core_ctl), .tap_state(tap_state));

// ===== verif/flag_reset_entry_tb.sv
module flag_reset_entry_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                       ref_clk = 1'b0;
   logic                       rst;
   flag_reset_pkg::flag_req_t  flag_req;
   logic                       pull_disable_wr;
   logic                       pull_disable_wdata;
   logic                       reset_n_pin, test_clk, test_mode_sel, boundary_scan_active;
   logic                       ext_flag_out, ext_flag_oe, internal_pullup;
   logic [15:0]                cpu_status_reg_one;
   flag_reset_pkg::core_ctl_t  core_ctl;
   flag_reset_pkg::tap_state_t tap_state;
   int                         n_errors = 0;
   int                         checks = 0;
   int                         cycles = 0;
   always #20 ref_clk = ~ref_clk;
   scan_host_model host_u (.ref_clk(ref_clk), .reset_n_pin(reset_n_pin), .test_clk(test_clk),
      .test_mode_sel(test_mode_sel), .boundary_scan_active(boundary_scan_active));
   flag_reset_entry dut_u (.ref_clk(ref_clk), .rst(rst), .reset_n_pin(reset_n_pin),
      .flag_req(flag_req), .pull_disable_wr(pull_disable_wr),
      .pull_disable_wdata(pull_disable_wdata), .test_clk(test_clk),
      .test_mode_sel(test_mode_sel), .boundary_scan_active(boundary_scan_active),
      .ext_flag_out(ext_flag_out), .ext_flag_oe(ext_flag_oe),
      .cpu_status_reg_one(cpu_status_reg_one), .internal_pullup(internal_pullup),
      .core_ctl(core_ctl), .tap_state(tap_state));
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One-cycle strobe, then look once the answering edge has landed
   task automatic pulse(input logic s, input logic c, input logic w, input logic [15:0] d);
      @(posedge ref_clk);
      flag_req <= '{set_instr: s, clear_instr: c, status_wr: w, status_wdata: d};
      @(posedge ref_clk);
      flag_req <= '0;
      #1;
   endtask : pulse
   task automatic t_flag();
      pulse(1'b1, 1'b0, 1'b0, 16'h0000);
      chk("flag set", ext_flag_out, 1'b1);
      chk("status mirror", cpu_status_reg_one[13], 1'b1);
      pulse(1'b0, 1'b1, 1'b0, 16'h0000);
      chk("flag clear", ext_flag_out, 1'b0);
      pulse(1'b0, 1'b0, 1'b1, 16'h2000);
      chk("status write", ext_flag_out, 1'b1);
      pulse(1'b0, 1'b1, 1'b1, 16'h2000);
      chk("clear beats write", ext_flag_out, 1'b0);
      pulse(1'b1, 1'b1, 1'b0, 16'h0000);
      chk("set beats clear", ext_flag_out, 1'b1);
      pulse(1'b0, 1'b0, 1'b1, 16'h5a5a);
      chk("status word", cpu_status_reg_one, 16'h5a5a);
      chk("flag from word", ext_flag_out, 1'b0);
      pulse(1'b1, 1'b0, 1'b0, 16'h0000);
      chk("status kept on set", cpu_status_reg_one, 16'h7a5a);
   endtask : t_flag
   task automatic t_scan();
      host_u.scan(1'b1);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("drive in scan", ext_flag_oe, 1'b0);
      host_u.scan(1'b0);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("drive after scan", ext_flag_oe, 1'b1);
   endtask : t_scan
   // Set strobe during pin reset must be ignored
   task automatic t_reset();
      @(posedge ref_clk);
      pull_disable_wr <= 1'b1;
      pull_disable_wdata <= 1'b1;
      @(posedge ref_clk);
      pull_disable_wr <= 1'b0;
      #1;
      chk("pull-up off", internal_pullup, 1'b0);
      host_u.drive_reset(1'b0);
      pulse(1'b1, 1'b0, 1'b0, 16'h0000);
      pulse(1'b0, 1'b0, 1'b0, 16'h0000);
      chk("forced pull-up", internal_pullup, 1'b1);
      chk("halted", core_ctl.run, 1'b0);
      chk("loading", core_ctl.pc_load, 1'b1);
      chk("vector", core_ctl.pc_value, flag_reset_pkg::RESET_VECTOR_ADDR);
      chk("status reset", cpu_status_reg_one, flag_reset_pkg::STATUS_ONE_RESET);
      host_u.drive_reset(1'b1);
      repeat (4) @(posedge ref_clk);
      #1;
      chk("running", core_ctl.run, 1'b1);
      chk("load done", core_ctl.pc_load, 1'b0);
      chk("boot address", core_ctl.pc_value, flag_reset_pkg::BOOTLOADER_ADDR);
      chk("flag ignored", ext_flag_out, flag_reset_pkg::FLAG_RESET_VAL);
      chk("pull-up kept off", internal_pullup, 1'b0);
      @(posedge ref_clk);
      pull_disable_wr <= 1'b1;
      pull_disable_wdata <= 1'b0;
      @(posedge ref_clk);
      pull_disable_wr <= 1'b0;
      #1;
      chk("pull-up back on", internal_pullup, 1'b1);
   endtask : t_reset
   task automatic t_tap();
      host_u.tck_step(1'b0);
      #1;
      chk("tap idle", tap_state, flag_reset_pkg::TAP_IDLE);
      host_u.tck_step(1'b1);
      #1;
      chk("tap select dr", tap_state, flag_reset_pkg::TAP_SEL_DR);
      host_u.tck_step(1'b1);
      #1;
      chk("tap select ir", tap_state, flag_reset_pkg::TAP_SEL_IR);
   endtask : t_tap
   task automatic results();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   // Whole run needs about 80 cycles; a hang is cut well beyond that
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         results();
      end
   end
   initial
   begin
      rst <= 1'b1;
      flag_req <= '0;
      pull_disable_wr <= 1'b0;
      pull_disable_wdata <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      t_flag();
      t_scan();
      t_reset();
      t_tap();
      results();
   end
endmodule : flag_reset_entry_tb
